// ---- src/nis_params.svh ----
`ifndef NIS_PARAMS_SVH
`define NIS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the wishbone bus)
// ----------------------------------------------------------------
`define NIS_OFF_NORMAL 12'h410
`define NIS_OFF_ERROR 12'h414
`define NIS_OFF_MASK 12'h418

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NIS_RST_REG 32'h0000_0000
`define NIS_RST_DATA 32'h0000_0000

// ----------------------------------------------------------------
// normal status field positions
// ----------------------------------------------------------------
`define NIS_BIT_ERR_SUMMARY 31
`define NIS_BIT_OUTBOUND 30
`define NIS_BIT_INBOUND 29
`define NIS_DMA_LSB 24
`define NIS_DMA_MAX 4
`define NIS_BIT_PCI_TWO 23
`define NIS_BIT_PCI_ONE 22
`define NIS_EXT_LSB 16
`define NIS_DB_LSB 8
`define NIS_MBOX_LSB 0

// ----------------------------------------------------------------
// masks of the bits that are real sticky flags
// ----------------------------------------------------------------
`define NIS_NORMAL_FLAGS 32'h2FFF_FFFF
`define NIS_PCI_TWO_MASK 32'h0080_0000
`define NIS_ERROR_FLAGS 32'h0EFE_FEFE
`define NIS_BIT_NORMAL_SUMMARY 31

`endif

// ---- src/nis_pkg.sv ----
package nis_pkg;

    // ------------------------------------------------------------
    // wishbone request as driven by the master
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } nis_wb_req_t;

    // ------------------------------------------------------------
    // write strobes handed from the bus slave to the registers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_normal;
        logic wr_error;
        logic wr_mask;
        logic [31:0] bits;
        logic [31:0] lanes;
    } nis_wr_t;

    // ------------------------------------------------------------
    // interrupt sources (pins active low, write events one cycle)
    // ------------------------------------------------------------
    typedef struct packed {
        logic outbound_post_pending;
        logic inbound_post_pending;
        logic pci_one_line_irq_n;
        logic pci_two_line_irq_n;
        logic [5:0] ext_line_irq_n;
        logic [7:0] doorbell_wr;
        logic [7:0] mailbox_wr;
    } nis_src_t;

    // ------------------------------------------------------------
    // per-module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } nis_bus_state_t;

    typedef struct packed {
        logic [31:0] flags;
    } nis_flag_state_t;

    typedef struct packed {
        logic [31:0] mask;
        logic irq;
    } nis_top_state_t;

endpackage : nis_pkg

// ---- src/nis_flag_bank.sv ----
`timescale 1ns/1ns
`include "nis_params.svh"

module nis_flag_bank #(
    parameter logic [31:0] VALID_MASK = 32'hFFFF_FFFF
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [31:0] set_i,
    input wire logic [31:0] clr_i,
    output logic [31:0] flags_o
);
    import nis_pkg::*;

    nis_flag_state_t st_ff;
    nis_flag_state_t nxt_st;
    logic [31:0] nxt_bit;

    // ------------------------------------------------------------
    // sticky flags, one per bit; bits outside the mask stay zero
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_flag
            // set wins so an event racing a clear is kept
            assign nxt_bit[gi] = VALID_MASK[gi] &
                (set_i[gi] | (st_ff.flags[gi] & ~clr_i[gi])); // [R13]
        end
    endgenerate

    // copy the next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.flags = nxt_bit;
    end

    // register the state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff.flags <= `NIS_RST_REG; // [R01]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign flags_o = st_ff.flags;

endmodule : nis_flag_bank

// ---- src/nis_wb_slave.sv ----
`timescale 1ns/1ns
`include "nis_params.svh"

module nis_wb_slave (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input nis_pkg::nis_wb_req_t wb_req_i,
    input wire logic [31:0] rd_normal_i,
    input wire logic [31:0] rd_error_i,
    input wire logic [31:0] rd_mask_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output nis_pkg::nis_wr_t wr_o
);
    import nis_pkg::*;

    nis_bus_state_t st_ff;
    nis_bus_state_t nxt_st;
    logic req_new;
    logic [31:0] lanes;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // a request is served once; the ack cycle blocks a second take
    assign req_new = wb_req_i.cyc & wb_req_i.stb & ~st_ff.ack;

    // byte lanes widened to a bit mask
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign lanes[gb*8 +: 8] = {8{wb_req_i.sel[gb]}};
        end
    endgenerate

    // write strobes, asserted in the cycle the ack is produced
    always_comb begin
        wr_o = '0;
        wr_o.bits = wb_req_i.dat & lanes;
        wr_o.lanes = lanes;
        if (req_new && wb_req_i.we) begin
            if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_NORMAL) begin
                wr_o.wr_normal = 1'b1;
            end else if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_ERROR) begin
                wr_o.wr_error = 1'b1;
            end else if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_MASK) begin
                wr_o.wr_mask = 1'b1;
            end
        end
    end

    // read data and ack; unmapped addresses answer zero
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req_new;
        if (req_new && !wb_req_i.we) begin
            if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_NORMAL) begin
                nxt_st.dat = rd_normal_i;
            end else if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_ERROR) begin
                nxt_st.dat = rd_error_i;
            end else if ({wb_req_i.adr[11:2], 2'b00} == `NIS_OFF_MASK) begin
                nxt_st.dat = rd_mask_i;
            end else begin
                nxt_st.dat = `NIS_RST_DATA;
            end
        end
    end

    // register the state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff.ack <= 1'b0;
            st_ff.dat <= `NIS_RST_DATA;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.dat;

endmodule : nis_wb_slave

// ---- src/nis_top.sv ----
// Overview of operation
// [R01] each flag sets while its source is active; global reset clears all flags
// [R02] bit 31 reads the OR of all error-status flags, read only
// [R03] bit 30 mirrors outbound post list status, read only
// [R04] inbound post pending sets its flag; write one clears it
// [R05] each DMA channel interrupt sets its own flag; write one clears
// [R06] PCI-1 INTA# low sets bit 22 flag; write one clears
// [R07] PCI-2 INTA# low sets bit 23; reserved on single-PCI builds
// [R08] six external line pins set bits 21:16; write one clears
// [R09] eight doorbell writes set bits 15:8; write one clears
// [R10] eight mailbox writes set bits 7:0; write one clears
// [R11] companion error-status register holds error conditions, write one clears
// [R12] zero writes leave flags alone; read-only bits ignore writes
// [R13] a set in the same cycle as a clear keeps the flag set
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "nis_params.svh"

module nis_top #(
    parameter int DMA_CHANNELS = 4,
    parameter bit DUAL_PCI = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input nis_pkg::nis_wb_req_t wb_req_i,
    input nis_pkg::nis_src_t src_i,
    input wire logic [DMA_CHANNELS-1:0] dma_channel_irq_i,
    input wire logic [31:0] err_event_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq_o
);
    import nis_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the dma field holds only four positions in the top byte
    generate
        if (DMA_CHANNELS < 1 || DMA_CHANNELS > `NIS_DMA_MAX) begin : g_bad_dma
            $error("DMA_CHANNELS must be 1 to 4");
        end
    endgenerate

    // ------------------------------------------------------------
    // constants derived from the build options
    // ------------------------------------------------------------
    // single-PCI builds keep the PCI-2 flag at zero forever
    localparam logic [31:0] NORMAL_VALID = DUAL_PCI ? `NIS_NORMAL_FLAGS
        : (`NIS_NORMAL_FLAGS & ~`NIS_PCI_TWO_MASK); // [R07]

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    nis_top_state_t st_ff;
    nis_top_state_t nxt_st;
    nis_wr_t wr;
    logic [31:0] normal_set;
    logic [31:0] normal_clr;
    logic [31:0] normal_flags;
    logic [31:0] normal_rd;
    logic [31:0] error_set;
    logic [31:0] error_clr;
    logic [31:0] error_flags;
    logic [31:0] error_rd;
    logic [3:0] dma_pad;
    logic error_any;
    logic normal_any;

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    nis_wb_slave u_bus (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .wb_req_i(wb_req_i),
        .rd_normal_i(normal_rd),
        .rd_error_i(error_rd),
        .rd_mask_i(st_ff.mask),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .wr_o(wr)
    );

    // ------------------------------------------------------------
    // normal status set sources
    // ------------------------------------------------------------
    // unused dma channels pad with zero so their flags never set
    assign dma_pad = 4'(dma_channel_irq_i);

    // level sources re-set a cleared flag while they stay active
    always_comb begin
        normal_set = '0;
        normal_set[`NIS_BIT_INBOUND] = src_i.inbound_post_pending; // [R04]
        normal_set[`NIS_DMA_LSB +: 4] = dma_pad; // [R05]
        normal_set[`NIS_BIT_PCI_ONE] = ~src_i.pci_one_line_irq_n; // [R06]
        normal_set[`NIS_BIT_PCI_TWO] = ~src_i.pci_two_line_irq_n; // [R07]
        normal_set[`NIS_EXT_LSB +: 6] = ~src_i.ext_line_irq_n; // [R08]
        normal_set[`NIS_DB_LSB +: 8] = src_i.doorbell_wr; // [R09]
        normal_set[`NIS_MBOX_LSB +: 8] = src_i.mailbox_wr; // [R10]
    end

    // write one clears; zeros and unselected lanes leave flags alone
    assign normal_clr = wr.wr_normal ? wr.bits : '0; // [R12]

    // ------------------------------------------------------------
    // normal status flags
    // ------------------------------------------------------------
    nis_flag_bank #(
        .VALID_MASK(NORMAL_VALID)
    ) u_normal (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(normal_set),
        .clr_i(normal_clr),
        .flags_o(normal_flags)
    );

    // ------------------------------------------------------------
    // error status: set sources and clears
    // ------------------------------------------------------------
    // only the documented error positions can ever hold a flag
    assign error_set = err_event_i & `NIS_ERROR_FLAGS; // [R11]
    assign error_clr = wr.wr_error ? wr.bits : '0; // [R12]

    nis_flag_bank #(
        .VALID_MASK(`NIS_ERROR_FLAGS)
    ) u_error (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .set_i(error_set),
        .clr_i(error_clr),
        .flags_o(error_flags)
    );

    // ------------------------------------------------------------
    // read views with the summary and mirror bits
    // ------------------------------------------------------------
    // summaries are pure ORs, so they clear the moment flags do
    assign error_any = |error_flags; // [R02]
    assign normal_any = |normal_flags;

    // read-only bits are composed here, never stored in a flag
    always_comb begin
        normal_rd = normal_flags;
        normal_rd[`NIS_BIT_ERR_SUMMARY] = error_any; // [R02]
        normal_rd[`NIS_BIT_OUTBOUND] = src_i.outbound_post_pending; // [R03]
    end

    // the error view carries the matching summary of normal flags
    always_comb begin
        error_rd = error_flags;
        error_rd[`NIS_BIT_NORMAL_SUMMARY] = normal_any; // [R11]
    end

    // ------------------------------------------------------------
    // mask register and interrupt line
    // ------------------------------------------------------------
    // mask honours byte lanes; irq lags status by one cycle
    always_comb begin
        nxt_st = st_ff;
        if (wr.wr_mask) begin
            nxt_st.mask = (st_ff.mask & ~wr.lanes) | wr.bits;
        end
        nxt_st.irq = |(normal_rd & st_ff.mask);
    end

    // register the state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff.mask <= `NIS_RST_REG;
            st_ff.irq <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign irq_o = st_ff.irq;

endmodule : nis_top

// ---- test/nis_top_assertions.sv ----
`timescale 1ns/1ns
`include "nis_params.svh"
module nis_top_assertions #(
    parameter int DMA_CHANNELS = 4,
    parameter bit DUAL_PCI = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input nis_pkg::nis_wb_req_t wb_req_i,
    input nis_pkg::nis_src_t src_i,
    input wire logic [DMA_CHANNELS-1:0] dma_channel_irq_i,
    input wire logic [31:0] err_event_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic irq_o
);
    import nis_pkg::*;
    logic tk;
    logic rn;
    // --------------------------------
    // taken request, read of normal status
    // --------------------------------
    assign tk = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    assign rn = tk && !wb_req_i.we && wb_req_i.adr == `NIS_OFF_NORMAL;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; tk |=> wb_ack_o ##1 !wb_ack_o; endproperty
    property p_db; src_i.doorbell_wr[0] ##1 rn |=> wb_dat_o[8]; endproperty
    property p_mb; src_i.mailbox_wr[7] ##1 rn |=> wb_dat_o[7]; endproperty
    property p_ext; !src_i.ext_line_irq_n[5] ##1 rn |=> wb_dat_o[21]; endproperty
    property p_pci; !src_i.pci_one_line_irq_n ##1 rn |=> wb_dat_o[22]; endproperty
    property p_inb; src_i.inbound_post_pending ##1 rn |=> wb_dat_o[29]; endproperty
    property p_dma; dma_channel_irq_i[0] ##1 rn |=> wb_dat_o[24]; endproperty
    property p_mir; rn |=> wb_dat_o[30] == $past(src_i.outbound_post_pending); endproperty
    a_ack: assert property (p_ack)
        else $error("ack not a single cycle after take");
    a_db: assert property (p_db)
        else $error("doorbell flag missing");
    a_mb: assert property (p_mb)
        else $error("mailbox flag missing");
    a_ext: assert property (p_ext)
        else $error("external line flag missing");
    a_pci: assert property (p_pci)
        else $error("pci one flag missing");
    a_inb: assert property (p_inb)
        else $error("inbound flag missing");
    a_dma: assert property (p_dma)
        else $error("dma flag missing");
    a_mir: assert property (p_mir)
        else $error("outbound mirror wrong");
    c_irq: cover property (irq_o);
    c_wr: cover property (tk && wb_req_i.we);
    c_rd: cover property (rn);
endmodule : nis_top_assertions

bind nis_top nis_top_assertions #(.DMA_CHANNELS(DMA_CHANNELS), .DUAL_PCI(DUAL_PCI)) u_chk (
    .sys_clk_i, .rst_i, .wb_req_i, .src_i, .dma_channel_irq_i, .err_event_i,
    .wb_ack_o, .wb_dat_o, .irq_o);

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`include "nis_params.svh"
module tb_top;
    import nis_pkg::*;
    localparam logic [25:0] src_idle = 26'h0FF_0000;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    nis_wb_req_t wb_req_i = '0;
    nis_src_t src_i = src_idle;
    logic [3:0] dma_channel_irq_i = 4'h0;
    logic [31:0] err_event_i = 32'h0;
    logic wb_ack_o, irq_o, m_ack, m_irq, tk;
    logic [31:0] wb_dat_o, m_nf, m_ef, m_mk, m_rd, nv, ev, ln, e, rdq;
    logic [31:0] rnd = 32'h25;
    int n_fail = 0;
    int checks = 0;
    int cyc_n = 0;
    nis_top dut_u (.sys_clk_i, .rst_i, .wb_req_i, .src_i, .dma_channel_irq_i,
        .err_event_i, .wb_ack_o, .wb_dat_o, .irq_o);
    always #20 sys_clk_i = ~sys_clk_i;
    // ------------------------------
    // reference model, one step per edge
    // ------------------------------
    always @(posedge sys_clk_i) begin
        nv = {|m_ef, src_i.outbound_post_pending, m_nf[29:0]};
        ev = {|m_nf, m_ef[30:0]};
        tk = wb_req_i.cyc && wb_req_i.stb && !m_ack;
        ln = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}},
            {8{wb_req_i.sel[0]}}} & {32{tk && wb_req_i.we}};
        m_ack <= !rst_i && tk;
        m_irq <= !rst_i && |(nv & m_mk);
        if (rst_i) m_rd <= 32'h0;
        else if (tk && !wb_req_i.we) m_rd <= wb_req_i.adr == `NIS_OFF_NORMAL ? nv :
            wb_req_i.adr == `NIS_OFF_ERROR ? ev : wb_req_i.adr == `NIS_OFF_MASK ? m_mk : 32'h0;
        m_nf <= rst_i ? 32'h0 : m_nf & ~(wb_req_i.adr == `NIS_OFF_NORMAL ? ln & wb_req_i.dat : 0)
            | {2'b00, src_i.inbound_post_pending, 1'b0, dma_channel_irq_i,
            ~src_i.pci_two_line_irq_n, ~src_i.pci_one_line_irq_n, ~src_i.ext_line_irq_n,
            src_i.doorbell_wr, src_i.mailbox_wr};
        m_ef <= rst_i ? 32'h0 : m_ef & ~(wb_req_i.adr == `NIS_OFF_ERROR ? ln & wb_req_i.dat : 0)
            | err_event_i & `NIS_ERROR_FLAGS;
        if (rst_i) m_mk <= 32'h0;
        else if (wb_req_i.adr == `NIS_OFF_MASK) m_mk <= m_mk & ~ln | wb_req_i.dat & ln;
    end
    // outputs compared mid-cycle, clear of the edge
    always @(negedge sys_clk_i) if (cyc_n > 1) begin
        chk("ack", 32'(wb_ack_o), 32'(m_ack));
        chk("irq", 32'(irq_o), 32'(m_irq));
        if (m_ack) chk("rdata", wb_dat_o, m_rd);
    end
    // hang guard
    always @(posedge sys_clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        for (int i = 0; i < 16; i++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction : lfsr
    // single classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
        input logic [31:0] d);
        wb_req_i <= '{1'b1, 1'b1, w, a, s, d};
        do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
        // read data taken at the very edge that sees ack high
        rdq = wb_dat_o;
        wb_req_i <= '0;
        @(posedge sys_clk_i);
    endtask : wb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        wb(1'b0, a, 4'hF, 32'h0);
        chk("read", rdq, x);
    endtask : rd
    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // ------------------------------
    // directed then random traffic
    // ------------------------------
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(`NIS_OFF_NORMAL, 32'h0);
        rd(`NIS_OFF_ERROR, 32'h0);
        rd(`NIS_OFF_MASK, 32'h0);
        // one pulse per source; pins 22, 23 swap, dma sits at 27:24
        for (int i = 0; i < 29; i++) begin
            src_i <= src_idle ^ (i < 25 ? 26'h1 << i : 26'h0);
            dma_channel_irq_i <= i > 24 ? 4'h1 << (i - 25) : 4'h0;
            @(posedge sys_clk_i);
            src_i <= src_idle;
            dma_channel_irq_i <= 4'h0;
            e = 32'h1 << (i > 24 ? i - 1 : i == 24 ? 29 : i == 23 ? 22 : i == 22 ? 23 : i);
            rd(`NIS_OFF_NORMAL, e);
            wb(1'b1, `NIS_OFF_NORMAL, 4'hF, e);
            rd(`NIS_OFF_NORMAL, 32'h0);
        end
        src_i <= src_idle ^ 26'h200_FFFF;
        err_event_i <= 32'h2;
        @(posedge sys_clk_i);
        src_i <= src_idle ^ 26'h200_0000;
        err_event_i <= 32'h0;
        @(posedge sys_clk_i);
        rd(`NIS_OFF_NORMAL, 32'hC000_FFFF);
        wb(1'b1, `NIS_OFF_NORMAL, 4'hF, 32'hD000_0000);
        wb(1'b1, `NIS_OFF_NORMAL, 4'h1, 32'h0000_FFFF);
        rd(`NIS_OFF_NORMAL, 32'hC000_FF00);
        rd(`NIS_OFF_ERROR, 32'h8000_0002);
        wb(1'b1, `NIS_OFF_ERROR, 4'hF, 32'h2);
        rd(`NIS_OFF_NORMAL, 32'h4000_FF00);
        // doorbell held high while software clears it
        src_i <= src_idle ^ 26'h200_0100;
        wb(1'b1, `NIS_OFF_NORMAL, 4'hF, 32'hFFFF_FFFF);
        rd(`NIS_OFF_NORMAL, 32'h4000_0100);
        wb(1'b1, `NIS_OFF_MASK, 4'hF, 32'h100);
        chk("irq", 32'(irq_o), 32'h1);
        wb(1'b1, 12'h41C, 4'hF, 32'hFFFF_FFFF);
        rd(12'h41C, 32'h0);
        for (int i = 0; i < 400; i++) begin
            rnd = lfsr(rnd);
            src_i <= nis_src_t'((rnd[25:0] & rnd[31:6]) ^ src_idle);
            dma_channel_irq_i <= rnd[3:0] & rnd[7:4];
            err_event_i <= rnd & {rnd[15:0], rnd[31:16]};
            wb(rnd[9], 12'h410 + {8'h00, rnd[11:10], 2'b00}, rnd[15:12], lfsr(rnd));
        end
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        src_i <= src_idle;
        dma_channel_irq_i <= 4'h0;
        err_event_i <= 32'h0;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(`NIS_OFF_NORMAL, 32'h0);
        give_verdict();
    end
endmodule : tb_top
